// [rtl/fpx_unit.sv]
// Floating-point exception and special-operand unit with register slave
`timescale 1ns/100ps
`default_nettype none
module fpx_unit #(
  parameter int ADDR_W = 4
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               req_valid,
  input  wire fpx_pkg::fpx_req_t  req,
  output var  logic               resp_valid,
  output var  fpx_pkg::fpx_resp_t resp,
  output var  logic               fp_error_out_n,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output var  logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output var  logic               s_axi_wready,
  output var  logic [1:0]         s_axi_bresp,
  output var  logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output var  logic               s_axi_arready,
  output var  logic [31:0]        s_axi_rdata,
  output var  logic [1:0]         s_axi_rresp,
  output var  logic               s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  if (ADDR_W < 4) begin : g_bad_addr
    $error("fpx_unit: ADDR_W must be at least 4");
  end

  function automatic fpx_pkg::fpx_cls_t classify(fpx_pkg::fpx_ext_t v);
    fpx_pkg::fpx_cls_t c;
    logic emax;
    emax = (v.exp == fpx_pkg::FPX_EXP_MAX);
    c.signaling_nan   = emax & v.sig[63] & ~v.sig[62] & (|v.sig[61:0]);
    c.quiet_nan   = emax & v.sig[63] & v.sig[62];
    c.unsup  = (emax & ~v.sig[63]) | (~emax & (|v.exp) & ~v.sig[63]);
    c.denorm = (v.exp == 15'h0000) & (|v.sig);
    return c;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Software-visible state
  logic [31:0] ctrl_q;
  logic [31:0] fpcw_q;
  logic [5:0]  sticky_q;
  logic [31:0] saved_ip_q;
  fpx_pkg::fpx_err_t err_q;
  fpx_pkg::fpx_err_t err_d;

  // Bus slave state
  logic awready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Instruction-side state
  logic resp_valid_q;
  fpx_pkg::fpx_resp_t resp_q;
  logic err_n_q;

  wire logic        ne      = ctrl_q[fpx_pkg::FPX_CTRL_NE];
  wire logic        ts_em   = ctrl_q[fpx_pkg::FPX_CTRL_TS]
                            | ctrl_q[fpx_pkg::FPX_CTRL_EM];
  wire logic [5:0]  mask    = fpcw_q[5:0];
  wire logic [1:0]  pc      = fpcw_q[fpx_pkg::FPX_CW_PC +: 2];
  wire logic [1:0]  rc      = fpcw_q[fpx_pkg::FPX_CW_RC +: 2];
  wire logic        deferred = fpcw_q[fpx_pkg::FPX_CW_DEF];

  // Register write decode
  wire logic aw_take = ce & s_axi_awvalid & s_axi_wvalid & ~awready_q
                     & ~bvalid_q;
  wire logic wr_en   = ce & awready_q;
  wire logic [3:0] wr_a = s_axi_awaddr[3:0];
  // Upper address bits must be zero, else no register is hit and SLVERR is returned
  wire logic wr_lo   = ~|(s_axi_awaddr >> 4);
  wire logic wr_ctrl = wr_en & wr_lo & (wr_a == fpx_pkg::FPX_ADDR_CTRL);
  wire logic wr_fpcw = wr_en & wr_lo & (wr_a == fpx_pkg::FPX_ADDR_FPCW);
  wire logic wr_stat = wr_en & wr_lo & (wr_a == fpx_pkg::FPX_ADDR_STAT);
  wire logic wr_map  = wr_lo & ((wr_a == fpx_pkg::FPX_ADDR_CTRL)
                     | (wr_a == fpx_pkg::FPX_ADDR_FPCW)
                     | (wr_a == fpx_pkg::FPX_ADDR_STAT)
                     | (wr_a == fpx_pkg::FPX_ADDR_IP));
  wire logic [31:0] stat_w1c = merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
  wire logic pend_clr = wr_stat & stat_w1c[fpx_pkg::FPX_ST_PEND];

  // Register read decode
  wire logic ar_take = ce & s_axi_arvalid & ~arready_q & ~rvalid_q;
  wire logic [3:0] rd_a = s_axi_araddr[3:0];
  wire logic rd_lo = ~|(s_axi_araddr >> 4);
  wire logic pend = (err_q != fpx_pkg::FPX_ERR_IDLE);
  wire logic [31:0] stat_rd = {23'h0, pend, 2'h0, sticky_q};
  wire logic rd_map = rd_lo & ((rd_a == fpx_pkg::FPX_ADDR_CTRL)
                    | (rd_a == fpx_pkg::FPX_ADDR_FPCW)
                    | (rd_a == fpx_pkg::FPX_ADDR_STAT)
                    | (rd_a == fpx_pkg::FPX_ADDR_IP));
  wire logic [31:0] rd_mux =
      (~rd_lo) ? 32'h00000000 :
      (rd_a == fpx_pkg::FPX_ADDR_CTRL) ? ctrl_q :
      (rd_a == fpx_pkg::FPX_ADDR_FPCW) ? fpcw_q :
      (rd_a == fpx_pkg::FPX_ADDR_STAT) ? stat_rd :
      (rd_a == fpx_pkg::FPX_ADDR_IP)   ? saved_ip_q : 32'h00000000;

  // Operand classification
  wire logic fire = ce & req_valid;
  wire fpx_pkg::fpx_cls_t cls = classify(req.opnd);
  wire fpx_pkg::fpx_cls_t rcl = classify(req.res);
  wire logic is_undef = (req.op == fpx_pkg::FPX_OP_UNDEF);
  wire logic quiet_nan_trap = (req.op == fpx_pkg::FPX_OP_CMP)
                       | (req.op == fpx_pkg::FPX_OP_ISTORE)
                       | (req.op == fpx_pkg::FPX_OP_BSTORE);
  wire logic conv_op = quiet_nan_trap & (req.op != fpx_pkg::FPX_OP_CMP);
  wire logic invalid = cls.signaling_nan | (cls.quiet_nan & quiet_nan_trap)
                     | cls.unsup;
  // Denormal is never invalid; every op class incl. transcendental flags it
  wire logic denorm = cls.denorm & ~invalid;
  // Denormal-to-stack path needs normalizing when DE is masked, and always for SQDVREM, ISTORE and BSTORE
  wire logic normalize = denorm & (mask[fpx_pkg::FPX_DE]
                       | (req.op == fpx_pkg::FPX_OP_SQDVREM)
                       | conv_op);
  wire logic ovf = req.res_overflow & ~invalid;
  wire logic unf = ~invalid & req.res_tiny
                 & (~mask[fpx_pkg::FPX_UE] | req.res_inexact);
  wire logic prec = ~invalid & (req.res_inexact
                  | ovf);
  // Fixed order: invalid masks the rest, denormal never masks arithmetic
  wire logic [5:0] exc = invalid ? 6'h01
                       : {prec, unf, ovf, 1'b0, denorm, 1'b0};
  wire logic unmasked = |(exc & ~mask);
  wire logic blocked = pend & ~is_undef;
  wire logic executes = ~ts_em & ~is_undef & ~blocked;

  // Result shaping
  wire logic [14:0] exp_ovf = req.res.exp - fpx_pkg::FPX_EXP_ADJ;
  wire logic [14:0] exp_unf = req.res.exp + fpx_pkg::FPX_EXP_ADJ;
  fpx_pkg::fpx_ext_t result;
  always_comb begin
    result = req.res;
    if (invalid & mask[fpx_pkg::FPX_IE]) begin
      result = '{1'b1, fpx_pkg::FPX_EXP_MAX, fpx_pkg::FPX_SIG_IND};
    end else if (rcl.signaling_nan | rcl.quiet_nan) begin
      result.sig[62] = 1'b1;
    end else if (ovf & mask[fpx_pkg::FPX_OE]) begin
      if (rc == fpx_pkg::FPX_RC_CHOP) begin
        result = '{req.res.sign, fpx_pkg::FPX_EXP_BIG,
                   fpx_pkg::FPX_SIG_BIG};
      end else begin
        result = '{req.res.sign, fpx_pkg::FPX_EXP_MAX,
                   fpx_pkg::FPX_SIG_INF};
      end
    end else if (ovf & req.res_stack_dst) begin
      result.exp = exp_ovf;
    end else if (unf & ~mask[fpx_pkg::FPX_UE] & req.res_stack_dst) begin
      result.exp = exp_unf;
    end
  end

  wire logic unf_trap = unf & ~mask[fpx_pkg::FPX_UE] & ~ovf;
  wire logic [1:0] rprec = req.pc_governed ? pc :
                           (unf_trap ? fpx_pkg::FPX_PC_EXT
                                     : req.op_prec);

  wire logic [7:0] vector =
      ts_em    ? fpx_pkg::FPX_VEC_NM :
      is_undef ? fpx_pkg::FPX_VEC_UD :
      (~blocked & unmasked & ne) ? fpx_pkg::FPX_VEC_MF
               : fpx_pkg::FPX_VEC_NONE;

  // External error reporting state
  wire logic raise = fire & executes & unmasked & ~ne;
  always_comb begin
    err_d = err_q;
    case (err_q)
      fpx_pkg::FPX_ERR_IDLE: begin
        if (raise) begin
          err_d = deferred ? fpx_pkg::FPX_ERR_PEND
                           : fpx_pkg::FPX_ERR_ASSERT;
        end
      end
      fpx_pkg::FPX_ERR_PEND: begin
        if (fire & ~ts_em & ~is_undef) begin
          err_d = fpx_pkg::FPX_ERR_ASSERT;
        end else if (pend_clr) begin
          err_d = fpx_pkg::FPX_ERR_IDLE;
        end
      end
      fpx_pkg::FPX_ERR_ASSERT: begin
        if (pend_clr) begin
          err_d = fpx_pkg::FPX_ERR_IDLE;
        end
      end
      default: err_d = fpx_pkg::FPX_ERR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 32'h00000000;
      fpcw_q <= {19'h0, 1'b0, fpx_pkg::FPX_RC_CHOP & 2'h0,
                 fpx_pkg::FPX_PC_RST, 2'h0, fpx_pkg::FPX_MASK_RST};
      sticky_q <= 6'h00;
      saved_ip_q <= 32'h00000000;
      err_q <= fpx_pkg::FPX_ERR_IDLE;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb) & 32'h0000002c;
      end
      if (wr_fpcw) begin
        fpcw_q <= merge(fpcw_q, s_axi_wdata, s_axi_wstrb) & 32'h00001f3f;
      end
      // Set wins over a same-cycle clear
      sticky_q <= (sticky_q & ~({6{wr_stat}} & stat_w1c[5:0]))
                | ({6{fire & executes}} & exc);
      if (fire & executes & |exc) begin
        saved_ip_q <= req.first_byte_ip;
      end
      err_q <= err_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid_q <= 1'b0;
      resp_q <= '0;
      err_n_q <= 1'b1;
    end else if (ce) begin
      resp_valid_q <= fire;
      if (fire) begin
        resp_q.fault <= (vector != fpx_pkg::FPX_VEC_NONE);
        resp_q.vector <= vector;
        resp_q.blocked <= ~ts_em & blocked;
        resp_q.exc <= executes ? exc : 6'h00;
        resp_q.normalize <= executes & normalize;
        resp_q.result <= result;
        resp_q.round_prec <= rprec;
      end
      // Pin feeds the outside controller in legacy mode
      err_n_q <= (err_d != fpx_pkg::FPX_ERR_ASSERT);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= fpx_pkg::FPX_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= fpx_pkg::FPX_OKAY;
    end else if (ce) begin
      awready_q <= aw_take;
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? fpx_pkg::FPX_OKAY : fpx_pkg::FPX_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= ar_take;
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? fpx_pkg::FPX_OKAY : fpx_pkg::FPX_SLVERR;
      end
      if (arready_q) begin
        rvalid_q <= 1'b1;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp = resp_q;
  assign fp_error_out_n = err_n_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_unmasked_done;
    fire & executes & unmasked & ~ne & ~deferred & ~pend_clr;
  endsequence
  sequence s_pin_low;
    !fp_error_out_n ##1 (!fp_error_out_n | !pend);
  endsequence

  chk_ne_reset: assert property ($past(!aresetn) |-> !ne)
    else $error("numeric-error flag not clear after reset");
  chk_quiet_nan: assert property (resp_valid & (resp.result.exp
      == fpx_pkg::FPX_EXP_MAX) & (|resp.result.sig[61:0])
      |-> resp.result.sig[62])
    else $error("signaling NaN produced as result");
  chk_signaling_nan_invalid: assert property (fire & executes & cls.signaling_nan
      |=> resp.exc[fpx_pkg::FPX_IE])
    else $error("signaling NaN did not raise invalid");
  chk_unsup_invalid: assert property (fire & executes & cls.unsup
      |=> resp.exc == 6'h01)
    else $error("unsupported encoding did not raise invalid");
  chk_chop_max: assert property (fire & executes & ovf
      & mask[fpx_pkg::FPX_OE] & ~(rcl.signaling_nan | rcl.quiet_nan)
      & (rc == fpx_pkg::FPX_RC_CHOP)
      |=> resp.result.exp == fpx_pkg::FPX_EXP_BIG)
    else $error("chopped overflow not largest finite");
  chk_ovf_prec: assert property (fire & executes & ovf
      |=> resp.exc[fpx_pkg::FPX_PE])
    else $error("overflow without precision flag");
  chk_vec_nm: assert property (fire & ts_em
      |=> resp_valid & (resp.vector == 8'h07))
    else $error("device-unavailable vector missing");
  chk_vec_ud: assert property (fire & ~ts_em & is_undef
      |=> (resp.vector == 8'h06) & ~resp.blocked)
    else $error("undefined opcode not vector 6");
  chk_pin_on_done: assert property (s_unmasked_done
      |=> s_pin_low)
    else $error("error pin not asserted at completion");
  chk_ip_prefix: assert property (fire & executes & |exc
      |=> saved_ip_q == $past(req.first_byte_ip))
    else $error("saved pointer not first prefix byte");
  chk_block_pend: assert property (fire & pend & ~ts_em & ~is_undef
      |=> resp.blocked & (resp.exc == 6'h00))
    else $error("instruction ran over pending error");

endmodule // fpx_unit
`default_nettype wire

// [rtl/fpx_pkg.sv]
// Constants, types and register map of the floating-point exception unit
package fpx_pkg;

  localparam logic [3:0] FPX_ADDR_CTRL  = 4'h0;
  localparam logic [3:0] FPX_ADDR_FPCW  = 4'h4;
  localparam logic [3:0] FPX_ADDR_STAT  = 4'h8;
  localparam logic [3:0] FPX_ADDR_IP    = 4'hc;

  localparam int FPX_CTRL_EM = 2;
  localparam int FPX_CTRL_TS = 3;
  localparam int FPX_CTRL_NE = 5;
  localparam int FPX_CW_PC   = 8;
  localparam int FPX_CW_RC   = 10;
  localparam int FPX_CW_DEF  = 12;
  localparam int FPX_ST_PEND = 8;

  localparam int FPX_IE = 0;
  localparam int FPX_DE = 1;
  localparam int FPX_OE = 3;
  localparam int FPX_UE = 4;
  localparam int FPX_PE = 5;

  localparam logic [5:0]  FPX_MASK_RST = 6'h3f;
  localparam logic [1:0]  FPX_PC_RST   = 2'h3;
  localparam logic [1:0]  FPX_PC_EXT   = 2'h3;
  localparam logic [1:0]  FPX_RC_CHOP  = 2'h3;
  localparam logic [1:0]  FPX_OKAY     = 2'h0;
  localparam logic [1:0]  FPX_SLVERR   = 2'h2;

  localparam logic [7:0]  FPX_VEC_NONE = 8'h00;
  localparam logic [7:0]  FPX_VEC_UD   = 8'h06;
  localparam logic [7:0]  FPX_VEC_NM   = 8'h07;
  localparam logic [7:0]  FPX_VEC_MF   = 8'h10;

  localparam logic [14:0] FPX_EXP_MAX  = 15'h7fff;
  localparam logic [14:0] FPX_EXP_BIG  = 15'h7ffe;
  localparam logic [14:0] FPX_EXP_ADJ  = 15'h6000;
  localparam logic [63:0] FPX_SIG_IND  = 64'hc000000000000000;
  localparam logic [63:0] FPX_SIG_INF  = 64'h8000000000000000;
  localparam logic [63:0] FPX_SIG_BIG  = 64'hffffffffffffffff;

  typedef enum logic [2:0] {
    FPX_OP_ARITH   = 3'h0,
    FPX_OP_CMP     = 3'h1,
    FPX_OP_ISTORE  = 3'h2,
    FPX_OP_BSTORE  = 3'h3,
    FPX_OP_TRANS   = 3'h4,
    FPX_OP_EXTRACT = 3'h5,
    FPX_OP_SQDVREM = 3'h6,
    FPX_OP_UNDEF   = 3'h7
  } fpx_op_t;

  typedef enum logic [2:0] {
    FPX_ERR_IDLE   = 3'b001,
    FPX_ERR_PEND   = 3'b010,
    FPX_ERR_ASSERT = 3'b100
  } fpx_err_t;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] sig;
  } fpx_ext_t;

  typedef struct packed {
    logic signaling_nan;
    logic quiet_nan;
    logic unsup;
    logic denorm;
  } fpx_cls_t;

  typedef struct packed {
    fpx_op_t     op;
    fpx_ext_t    opnd;
    logic [31:0] first_byte_ip;
    logic        pc_governed;
    logic [1:0]  op_prec;
    fpx_ext_t    res;
    logic        res_overflow;
    logic        res_tiny;
    logic        res_inexact;
    logic        res_stack_dst;
  } fpx_req_t;

  typedef struct packed {
    logic        fault;
    logic [7:0]  vector;
    logic        blocked;
    logic [5:0]  exc;
    logic        normalize;
    fpx_ext_t    result;
    logic [1:0]  round_prec;
  } fpx_resp_t;

endpackage

// [sim/fpx_irq_model.sv]
// Interrupt controller model fed by the floating-point error pin
`timescale 1ns/100ps
`default_nettype none
module fpx_irq_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic fp_error_out_n,
  output var  logic maskable_irq_pin
);
  // One flop of delay; a level request, the core clears it at the source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maskable_irq_pin <= 1'b0;
    end else begin
      maskable_irq_pin <= !fp_error_out_n;
    end
  end
endmodule // fpx_irq_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the floating-point exception unit
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [79:0] NRM = {1'b0, 15'h3fff, 64'h8000000000000000};
  localparam logic [79:0] OPV [4] = '{{1'b0, 15'h7fff, 64'ha000000000000000},
    {1'b0, 15'h7fff, 64'hc000000000000001},
    {1'b0, 15'h3fff, 64'h4000000000000000}, {1'b0, 15'h0, 64'h1}};
  logic               aclk, aresetn, ce, req_valid, resp_valid;
  logic               fp_error_out_n, irq;
  fpx_pkg::fpx_req_t  req, r;
  fpx_pkg::fpx_resp_t resp, ex;
  logic [4:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata, cw, ctl;
  logic [3:0]         s_axi_wstrb;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic               s_axi_rready;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [5:0]         st;
  int                 err_total, total_checks, pend, rchk;

  fpx_unit #(.ADDR_W(5)) DUT (.aclk, .aresetn, .ce, .req_valid, .req,
    .resp_valid, .resp, .fp_error_out_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fpx_irq_model u_irq (.aclk, .aresetn, .fp_error_out_n,
    .maskable_irq_pin(irq));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic test_done();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(string nm, logic [79:0] e, logic [79:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  // Bounded wait: a hung handshake ends the run as a failure
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      err_total++;
      test_done();
    end
  endtask

  task automatic axw(logic [4:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do tick(n); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do tick(n); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp("bresp", er, s_axi_bresp);
    if (a == 5'h00) ctl = d;
    if (a == 5'h04) cw = d;
    if (a == 5'h08) begin
      st &= ~d[5:0];
      if (d[8]) pend = 0;
    end
  endtask

  task automatic axr(logic [4:0] a, logic [31:0] e, logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", er, s_axi_rresp);
  endtask

  function automatic fpx_pkg::fpx_req_t mk(int op, logic [79:0] v);
    fpx_pkg::fpx_req_t q;
    q = '0;
    q.op = fpx_pkg::fpx_op_t'(op[2:0]);
    q.opnd = v;
    q.res = {v[79], 15'h4000, 64'h8000000000000000};
    q.first_byte_ip = $urandom;
    q.op_prec = 2'h1;
    q.res_stack_dst = 1'b1;
    return q;
  endfunction

  task automatic model(fpx_pkg::fpx_req_t q);
    logic inv, dn;
    logic [5:0] m;
    fpx_pkg::fpx_ext_t o;
    o = q.opnd;
    m = cw[5:0];
    ex = '0;
    rchk = 0;
    dn = o.exp == 15'h0 && o.sig != 64'h0;
    inv = o.exp != 15'h0 && !o.sig[63] || o.exp == 15'h7fff && o.sig[63:62]
      == 2'b10 && o.sig[61:0] != 62'h0 || o.exp == 15'h7fff && o.sig[62]
      && q.op inside {[3'h1:3'h3]};
    if (ctl[2] || ctl[3]) begin
      ex.vector = 8'h07;
    end else if (q.op == 3'h7) begin
      ex.vector = 8'h06;
    end else if (pend != 0) begin
      ex.blocked = 1'b1;
      pend = 2;
    end else begin
      ex.exc = inv ? 6'h01 : {q.res_inexact | q.res_overflow,
        q.res_tiny & (q.res_inexact | !m[4]), q.res_overflow, 1'b0, dn, 1'b0};
      ex.normalize = dn && !inv && (m[1] || q.op inside {3'h2, 3'h3, 3'h6});
      st |= ex.exc;
      if (|(ex.exc & ~m)) begin
        if (ctl[5]) ex.vector = 8'h10;
        else pend = cw[12] ? 1 : 2;
      end
      rchk = 2;
      if (inv && m[0]) begin
        rchk = 1;
        ex.result = {1'b1, 15'h7fff, 64'hc000000000000000};
      end else if (q.res.exp == 15'h7fff && q.res.sig[63]
          && q.res.sig[62:0] != 63'h0) begin
        rchk = 1;
        ex.result = q.res;
        ex.result.sig[62] = 1'b1;
      end else if (ex.exc[3] && m[3]) begin
        rchk = 1;
        ex.result = cw[11:10] == 2'h3 ? {q.res.sign, 15'h7ffe, {64{1'b1}}}
          : {q.res.sign, 15'h7fff, 64'h8000000000000000};
      end else if (ex.exc[3]) begin
        ex.result.exp = q.res.exp - 15'h6000;
        ex.round_prec = q.pc_governed ? cw[9:8] : q.op_prec;
      end else if (ex.exc[4] && !m[4]) begin
        ex.result.exp = q.res.exp + 15'h6000;
        ex.round_prec = q.pc_governed ? cw[9:8] : 2'h3;
      end else begin
        rchk = 0;
      end
    end
  endtask

  // Response lands one edge after the taking edge, as handed over
  task automatic ins(fpx_pkg::fpx_req_t q);
    req <= q;
    req_valid <= 1'b1;
    @(posedge aclk);
    req_valid <= 1'b0;
    model(q);
    @(posedge aclk);
    cmp("resp_valid", 1'b1, resp_valid);
    cmp("vector", ex.vector, resp.vector);
    cmp("fault", ex.vector != 8'h00, resp.fault);
    cmp("blocked", ex.blocked, resp.blocked);
    cmp("exc", ex.exc, resp.exc);
    cmp("normalize", ex.normalize, resp.normalize);
    cmp("err_pin", pend != 2, fp_error_out_n);
    if (rchk == 1) cmp("result", ex.result, resp.result);
    if (rchk == 2) cmp("exp_prec", {ex.result.exp, ex.round_prec},
      {resp.result.exp, resp.round_prec});
  endtask

  initial begin
    {ce, aresetn, req_valid, s_axi_awvalid, s_axi_wvalid} = 5'h10;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {req, r, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {err_total, total_checks, pend, st, ctl} = '0;
    cw = 32'h033f;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    void'($urandom(32'hcd6f4cd7));
    axr(5'h00, 32'h0, 2'h0);
    axr(5'h04, 32'h033f, 2'h0);
    axr(5'h08, 32'h0, 2'h0);
    axr(5'h0c, 32'h0, 2'h0);
    axr(5'h10, 32'h0, 2'h2);
    axw(5'h10, 32'h1, 2'h2);
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (k != 2 || i == 0) begin
          r = mk(i, OPV[k]);
          if (k == 1) r.res = OPV[0];
          ins(r);
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      axw(5'h04, k[1] ? 32'h0f3f : 32'h033f, 2'h0);
      r = mk(0, NRM ^ {k[0], 79'h0});
      {r.res_overflow, r.res_inexact} = 2'b11;
      ins(r);
    end
    for (int k = 0; k < 2; k++) begin
      r = mk(0, NRM);
      {r.res_tiny, r.res_inexact} = {1'b1, k[0]};
      ins(r);
    end
    // Denormal masked and unmasked, arithmetic then root or divide
    for (int k = 0; k < 4; k++) begin
      axw(5'h04, k[0] ? 32'h033d : 32'h033f, 2'h0);
      r = mk(k[1] ? 6 : 0, OPV[3]);
      {r.res_overflow, r.res_inexact} = 2'b11;
      ins(r);
      axw(5'h08, 32'h013f, 2'h0);
    end
    axw(5'h04, 32'h0237, 2'h0);
    r = mk(0, NRM);
    {r.res_overflow, r.pc_governed} = 2'b11;
    ins(r);
    @(posedge aclk);
    cmp("irq", 1'b1, irq);
    axr(5'h0c, r.first_byte_ip, 2'h0);
    ins(mk(7, NRM));
    ins(mk(0, NRM));
    axr(5'h08, {23'h0, pend != 0, 2'h0, st}, 2'h0);
    axw(5'h08, 32'h013f, 2'h0);
    axw(5'h04, 32'h022f, 2'h0);
    r = mk(0, NRM);
    {r.res_tiny, r.res_inexact} = 2'b11;
    ins(r);
    axw(5'h08, 32'h013f, 2'h0);
    axw(5'h04, 32'h1237, 2'h0);
    r.res_overflow = 1'b1;
    ins(r);
    ins(r);
    axw(5'h08, 32'h013f, 2'h0);
    axw(5'h00, 32'h0020, 2'h0);
    axr(5'h00, 32'h0020, 2'h0);
    ins(r);
    // Clock enable low: a held request must not be taken
    ce <= 1'b0;
    req_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp("ce_freeze", 1'b0, resp_valid);
    ce <= 1'b1;
    req_valid <= 1'b0;
    for (int k = 2; k < 4; k++) begin
      axw(5'h00, 32'h1 << k, 2'h0);
      ins(mk(0, NRM));
      ins(mk(7, NRM));
    end
    axw(5'h00, 32'h0, 2'h0);
    axw(5'h04, 32'h033f, 2'h0);
    // Random normal operands, all exceptions masked
    for (int n = 0; n < 40; n++) begin
      r = mk($urandom_range(6), {1'($urandom),
        15'($urandom_range(32766, 1)), 1'b1, 63'($urandom)});
      {r.res_tiny, r.res_inexact} = 2'($urandom);
      ins(r);
    end
    axr(5'h08, {23'h0, pend != 0, 2'h0, st}, 2'h0);
    test_done();
  end
endmodule // tb
`default_nettype wire
